/* logic/uart_8bit_9bit_wakeup.sv */
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module uart_8bit_9bit_wakeup (
    // Clock and reset.
    input wire logic mclk,
    input wire logic arst_n,
    // Register port.
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Serial line.
    input wire logic rxd,
    output logic txd,
    // Interrupt.
    output logic irq
);
    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP
    } tx_state_t;

    // ****************************************************************
    // Parity of a byte: the bit that makes the ones count even or odd.
    // ****************************************************************
    function automatic logic parity_fn(input logic [7:0] d,
                                       input logic even);
        parity_fn = even ? (^d) : ~(^d);
    endfunction : parity_fn

    logic [7:0] mode_q, baud_q, baud_cnt_q, rbuf_q, tx_shift_q;
    logic [1:0] int_stat_q, int_en_q;
    logic even_q, pe_q, rb8_q, ovr_q, perr_q, ferr_q, rx_full_q;
    logic tick, uart_mode, nine, receive_enable_bit, wu, rx_en;
    logic rx_done, rx_extra, rx_stop_ok, rx_keep, rx_perr;
    logic [7:0] rx_data;
    tx_state_t tx_state_q;
    logic [3:0] tx_tcnt_q;
    logic [2:0] tx_idx_q;
    logic tx_extra_q, tx_has_extra_q, tx_done_q, tx_go;
    logic wr_mode, wr_ctrl, wr_data, wr_baud, wr_clr, wr_en;
    logic rd_ctrl, rd_data;

    // ****************************************************************
    // Register decode.
    // ****************************************************************
    assign wr_mode = reg_wr && (reg_addr == uart_pkg::ADDR_MODE);
    assign wr_ctrl = reg_wr && (reg_addr == uart_pkg::ADDR_CTRL);
    assign wr_data = reg_wr && (reg_addr == uart_pkg::ADDR_DATA);
    assign wr_baud = reg_wr && (reg_addr == uart_pkg::ADDR_BAUD);
    assign wr_clr = reg_wr && (reg_addr == uart_pkg::ADDR_INT_CLR);
    assign wr_en = reg_wr && (reg_addr == uart_pkg::ADDR_INT_EN);
    assign rd_ctrl = reg_rd && (reg_addr == uart_pkg::ADDR_CTRL);
    assign rd_data = reg_rd && (reg_addr == uart_pkg::ADDR_DATA);

    // Mode field: only 10 and 11 run the asynchronous channel.
    assign uart_mode = mode_q[uart_pkg::MODE_FM_LSB + 1];
    assign nine = (mode_q[uart_pkg::MODE_FM_LSB +: 2]
        == uart_pkg::FM_9BIT);
    assign receive_enable_bit = mode_q[uart_pkg::MODE_RXE_BIT];
    assign wu = mode_q[uart_pkg::MODE_WU_BIT];
    assign rx_en = receive_enable_bit && uart_mode;

    // ****************************************************************
    // Control registers written by software.
    // ****************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= uart_pkg::MODE_RST;
        end else if (wr_mode) begin
            // Software clears wakeup here once its select code matches.
            mode_q <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            even_q <= 1'b0;
            pe_q <= 1'b0;
        end else if (wr_ctrl) begin
            even_q <= reg_wdata[uart_pkg::CTRL_EVEN_BIT];
            pe_q <= reg_wdata[uart_pkg::CTRL_PE_BIT];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            baud_q <= uart_pkg::BAUD_RST;
        end else if (wr_baud) begin
            baud_q <= reg_wdata;
        end
    end

    // ****************************************************************
    // Baud tick: one tick every (divisor + 1) clocks, 16 ticks a bit.
    // ****************************************************************
    assign tick = (baud_cnt_q == baud_q);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            baud_cnt_q <= 8'h00;
        end else if (tick) begin
            baud_cnt_q <= 8'h00;
        end else begin
            baud_cnt_q <= baud_cnt_q + 8'h01;
        end
    end

    // ****************************************************************
    // Transmitter. A buffer write while a frame is in flight is dropped.
    // ****************************************************************
    assign tx_go = wr_data && (tx_state_q == TX_IDLE) && uart_mode;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tx_state_q <= TX_IDLE;
            tx_tcnt_q <= 4'h0;
            tx_idx_q <= 3'h0;
            tx_shift_q <= 8'h00;
            tx_extra_q <= 1'b0;
            tx_has_extra_q <= 1'b0;
            tx_done_q <= 1'b0;
            txd <= 1'b1;
        end else begin
            tx_done_q <= 1'b0;
            if (!uart_mode) begin
                tx_state_q <= TX_IDLE;
                txd <= 1'b1;
            end else if (tx_go) begin
                tx_shift_q <= reg_wdata;
                // Ninth bit in 9-bit mode, else parity when enabled.
                tx_extra_q <= nine ? mode_q[uart_pkg::MODE_TX9_BIT]
                    : parity_fn(reg_wdata, even_q);
                tx_has_extra_q <= nine || pe_q;
                tx_tcnt_q <= 4'h0;
                tx_state_q <= TX_START;
                txd <= 1'b0;
            end else if (tick && tx_state_q != TX_IDLE) begin
                tx_tcnt_q <= tx_tcnt_q + 4'h1;
                if (tx_tcnt_q == uart_pkg::TICK_LAST) begin
                    unique case (tx_state_q)
                        TX_START: begin
                            tx_idx_q <= 3'h0;
                            tx_state_q <= TX_DATA;
                            txd <= tx_shift_q[0];
                        end
                        TX_DATA: begin
                            if (tx_idx_q == uart_pkg::BIT_LAST) begin
                                if (tx_has_extra_q) begin
                                    tx_state_q <= TX_EXTRA;
                                    txd <= tx_extra_q;
                                end else begin
                                    tx_state_q <= TX_STOP;
                                    txd <= 1'b1;
                                end
                            end else begin
                                tx_idx_q <= tx_idx_q + 3'h1;
                                txd <= tx_shift_q[tx_idx_q + 3'h1];
                            end
                        end
                        TX_EXTRA: begin
                            tx_state_q <= TX_STOP;
                            txd <= 1'b1;
                        end
                        TX_STOP: begin
                            tx_state_q <= TX_IDLE;
                            tx_done_q <= 1'b1;
                        end
                        TX_IDLE: begin
                            txd <= 1'b1;
                        end
                    endcase
                end
            end
        end
    end

    // ****************************************************************
    // Receiver core and frame acceptance.
    // ****************************************************************
    uart_rx_core u_rx (
        .mclk(mclk),
        .arst_n(arst_n),
        .rxd(rxd),
        .tick(tick),
        .enable(rx_en),
        .has_extra(nine || pe_q),
        .done(rx_done),
        .data(rx_data),
        .extra(rx_extra),
        .stop_ok(rx_stop_ok)
    );

    // A slave waiting for its address drops frames with ninth bit 0.
    assign rx_keep = rx_done && !(nine && wu && !rx_extra);
    assign rx_perr = rx_keep && !nine && pe_q
        && (rx_extra != parity_fn(rx_data, even_q));

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rbuf_q <= 8'h00;
            rb8_q <= 1'b0;
        end else if (rx_keep) begin
            rbuf_q <= rx_data;
            if (nine) begin
                rb8_q <= rx_extra;
            end
        end
    end

    // Buffer full flag: a new frame wins over a read in the same cycle.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rx_full_q <= 1'b0;
        end else if (rx_keep) begin
            rx_full_q <= 1'b1;
        end else if (rd_data) begin
            rx_full_q <= 1'b0;
        end
    end

    // Error flags clear on a read of the control register; set wins.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ovr_q <= 1'b0;
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
        end else begin
            ovr_q <= (ovr_q && !rd_ctrl) || (rx_keep && rx_full_q);
            perr_q <= (perr_q && !rd_ctrl) || rx_perr;
            ferr_q <= (ferr_q && !rd_ctrl) || (rx_keep && !rx_stop_ok);
        end
    end

    // ****************************************************************
    // Interrupt status, clear and enable.
    // ****************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            int_stat_q <= uart_pkg::INT_RST;
        end else begin
            int_stat_q <= (int_stat_q & ~(wr_clr ? reg_wdata[1:0] : 2'h0))
                | {tx_done_q, rx_keep};
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            int_en_q <= uart_pkg::INT_RST;
        end else if (wr_en) begin
            int_en_q <= reg_wdata[1:0];
        end
    end

    assign irq = |(int_stat_q & int_en_q);

    // ****************************************************************
    // Read data, one cycle after the read strobe.
    // ****************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                uart_pkg::ADDR_MODE: reg_rdata <= mode_q;
                uart_pkg::ADDR_CTRL: begin
                    reg_rdata <= {rb8_q, even_q, pe_q, ovr_q, perr_q,
                                  ferr_q, 2'h0};
                end
                uart_pkg::ADDR_DATA: reg_rdata <= rbuf_q;
                uart_pkg::ADDR_BAUD: reg_rdata <= baud_q;
                uart_pkg::ADDR_INT_STAT: reg_rdata <= {6'h00, int_stat_q};
                uart_pkg::ADDR_INT_EN: reg_rdata <= {6'h00, int_en_q};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence s_launch;
        tx_go;
    endsequence

    sequence s_start_bit;
        (tx_state_q == TX_START) && !txd;
    endsequence

    AST_TX_START: assert property (s_launch |=> s_start_bit)
        else $error("start bit not driven low after buffer write");

    AST_TX_LAUNCH_MODE: assert property (
        $rose(tx_state_q == TX_START) |-> $past(uart_mode))
        else $error("frame launched outside a UART mode");

    AST_TX_STOP_HIGH: assert property (
        (tx_state_q == TX_STOP) |-> txd)
        else $error("stop bit not high");

    AST_TX_PARITY: assert property (
        (tx_state_q == TX_EXTRA) && !nine |-> pe_q
        && (txd == parity_fn(tx_shift_q, even_q)))
        else $error("wrong parity bit on line");

    AST_TX_NINTH: assert property (
        tx_go && nine |=> tx_has_extra_q
        && (tx_extra_q == $past(mode_q[uart_pkg::MODE_TX9_BIT])))
        else $error("ninth bit not taken from mode register");

    AST_NO_PARITY_9BIT: assert property (
        $rose(perr_q) |-> !$past(nine) && $past(pe_q))
        else $error("parity checked outside 8-bit mode");

    AST_RB8_STORE: assert property (
        rx_done && nine && !(wu && !rx_extra) |=>
        rb8_q == $past(rx_extra))
        else $error("received ninth bit not stored");

    AST_WAKEUP_FILTER: assert property (
        rx_done && nine && wu && !rx_extra |=>
        (int_stat_q[0] == $past(int_stat_q[0]) || !int_stat_q[0])
        && rbuf_q == $past(rbuf_q))
        else $error("frame with ninth bit 0 passed wakeup filter");

    AST_RX_ENABLE: assert property (
        !rx_en ##1 !rx_en |-> !rx_done)
        else $error("frame received while reception disabled");

endmodule : uart_8bit_9bit_wakeup

/* logic/uart_pkg.sv */
package uart_pkg;

    // ****************************************************************
    // Register offsets on the plain register port.
    // ****************************************************************
    localparam logic [2:0] ADDR_MODE = 3'h0;
    localparam logic [2:0] ADDR_CTRL = 3'h1;
    localparam logic [2:0] ADDR_DATA = 3'h2;
    localparam logic [2:0] ADDR_BAUD = 3'h3;
    localparam logic [2:0] ADDR_INT_STAT = 3'h4;
    localparam logic [2:0] ADDR_INT_CLR = 3'h5;
    localparam logic [2:0] ADDR_INT_EN = 3'h6;

    // ****************************************************************
    // Field positions.
    // ****************************************************************
    localparam int MODE_TX9_BIT = 7;
    localparam int MODE_RXE_BIT = 5;
    localparam int MODE_WU_BIT = 4;
    localparam int MODE_FM_LSB = 2;
    localparam int CTRL_RX9_BIT = 7;
    localparam int CTRL_EVEN_BIT = 6;
    localparam int CTRL_PE_BIT = 5;
    localparam int CTRL_OVR_BIT = 4;
    localparam int CTRL_PAR_BIT = 3;
    localparam int CTRL_FRM_BIT = 2;
    localparam int INT_RX_BIT = 0;
    localparam int INT_TX_BIT = 1;

    // ****************************************************************
    // Encodings and reset values.
    // ****************************************************************
    localparam logic [1:0] FM_8BIT = 2'h2;
    localparam logic [1:0] FM_9BIT = 2'h3;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [1:0] INT_RST = 2'h0;
    localparam logic [7:0] CTRL_WR_MASK = 8'h60;

    // ****************************************************************
    // Timing counts, in baud ticks (16 ticks per bit), and the last data bit index.
    // ****************************************************************
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] TICK_HALF = 4'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;

endpackage : uart_pkg

/* logic/uart_rx_core.sv */
`timescale 1ns/100ps
module uart_rx_core (
    // Clock and reset.
    input wire logic mclk,
    input wire logic arst_n,
    // Line and timing.
    input wire logic rxd,
    input wire logic tick,
    input wire logic enable,
    input wire logic has_extra,
    // Received frame.
    output logic done,
    output logic [7:0] data,
    output logic extra,
    output logic stop_ok
);
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP
    } rx_state_t;

    rx_state_t state_q;
    logic s1_q, s2_q, s3_q, level_q;
    logic [3:0] tcnt_q;
    logic [2:0] idx_q;

    // ****************************************************************
    // Input synchroniser; a change counts once stages two and three agree.
    // ****************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            level_q <= 1'b1;
        end else begin
            s1_q <= rxd;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

    // ****************************************************************
    // Frame sampler: start checked mid-bit, later bits every 16 ticks.
    // ****************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= RX_IDLE;
            tcnt_q <= 4'h0;
            idx_q <= 3'h0;
            done <= 1'b0;
            data <= 8'h00;
            extra <= 1'b0;
            stop_ok <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!enable) begin
                state_q <= RX_IDLE;
            end else if (state_q == RX_IDLE) begin
                if (!level_q) begin
                    state_q <= RX_START;
                    tcnt_q <= 4'h0;
                end
            end else if (tick) begin
                tcnt_q <= tcnt_q + 4'h1;
                unique case (state_q)
                    RX_START: begin
                        if (tcnt_q == uart_pkg::TICK_HALF) begin
                            tcnt_q <= 4'h0;
                            idx_q <= 3'h0;
                            state_q <= level_q ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        if (tcnt_q == uart_pkg::TICK_LAST) begin
                            data <= {level_q, data[7:1]};
                            idx_q <= idx_q + 3'h1;
                            if (idx_q == uart_pkg::BIT_LAST) begin
                                state_q <= has_extra ? RX_EXTRA : RX_STOP;
                            end
                        end
                    end
                    RX_EXTRA: begin
                        if (tcnt_q == uart_pkg::TICK_LAST) begin
                            extra <= level_q;
                            state_q <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        if (tcnt_q == uart_pkg::TICK_LAST) begin
                            stop_ok <= level_q;
                            done <= 1'b1;
                            state_q <= RX_IDLE;
                        end
                    end
                    RX_IDLE: begin
                        tcnt_q <= 4'h0;
                    end
                endcase
            end
        end
    end

endmodule : uart_rx_core

/* bench/uart_peer.sv */
`timescale 1ns/100ps
module uart_peer (
    // Clock.
    input wire logic mclk,
    // Serial lines.
    input wire logic line_in,
    output logic line_out
);
    int nbits = 10;
    logic [9:0] got_q = '0;

    initial line_out = 1'b1;

    // ****************************************************************
    // Sender: start, n bits LSB first, stop; the top bit is the extra.
    // ****************************************************************
    task automatic send(input logic [9:0] d, input int n);
        int i;
        @(posedge mclk) line_out <= 1'b0;
        repeat (16) @(posedge mclk);
        for (i = 0; i < n; i++) begin
            line_out <= d[i];
            repeat (16) @(posedge mclk);
        end
        line_out <= 1'b1;
        repeat (16) @(posedge mclk);
    endtask : send

    // ****************************************************************
    // Receiver: samples each bit in its middle, stop bit last.
    // ****************************************************************
    always begin
        @(negedge line_in);
        repeat (8) @(posedge mclk);
        for (int i = 0; i < nbits; i++) begin
            repeat (16) @(posedge mclk);
            got_q[i] = line_in;
        end
    end
endmodule : uart_peer

/* bench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic mclk, arst_n, reg_wr, reg_rd, txd, irq, rxd;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;

    uart_8bit_9bit_wakeup DUT (.mclk(mclk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd),
        .irq(irq));
    uart_peer peer (.mclk(mclk), .line_in(txd), .line_out(rxd));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ****************************************************************
    // Helpers.
    // ****************************************************************
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [9:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = {2'h0, reg_rdata};
    endtask : rd

    task automatic ck_rd(input logic [2:0] a, input logic [9:0] exp);
        logic [9:0] v;
        rd(a, v);
        check(v, exp);
    endtask : ck_rd

    task automatic ck_irq(input logic exp);
        @(posedge mclk);
        #1 check({9'h0, irq}, {9'h0, exp});
    endtask : ck_irq

    task automatic tx_check(input logic [7:0] m, input logic [7:0] c,
                            input int nb, input logic [9:0] exp);
        logic [9:0] v;
        int n;
        peer.nbits = nb;
        peer.got_q = '0;
        wr(uart_pkg::ADDR_MODE, m);
        wr(uart_pkg::ADDR_CTRL, c);
        wr(uart_pkg::ADDR_DATA, 8'h31);
        v = '0;
        for (n = 0; n < 300 && v[1] !== 1'b1; n++) begin
            rd(uart_pkg::ADDR_INT_STAT, v);
        end
        check(v, 10'h002);
        repeat (12) @(posedge mclk);
        check(peer.got_q, exp);
        wr(uart_pkg::ADDR_INT_CLR, 8'h03);
    endtask : tx_check

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic t_reset;
        ck_rd(uart_pkg::ADDR_MODE, 10'h000);
        ck_rd(uart_pkg::ADDR_INT_STAT, 10'h000);
        ck_rd(3'h7, 10'h000);
        wr(uart_pkg::ADDR_BAUD, 8'h03);
        ck_rd(uart_pkg::ADDR_BAUD, 10'h003);
        wr(uart_pkg::ADDR_BAUD, 8'h00);
        // Channel off: this buffer write must not start a frame.
        wr(uart_pkg::ADDR_DATA, 8'h31);
        wr(uart_pkg::ADDR_MODE, 8'h3c);
        ck_rd(uart_pkg::ADDR_MODE, 10'h03c);
        check({9'h0, txd}, 10'h001);
        // Let the divisor counter wrap back after the rate change.
        repeat (260) @(posedge mclk);
    endtask : t_reset

    task automatic t_tx;
        tx_check(8'h28, 8'h00, 9, 10'h131);
        tx_check(8'h28, 8'h60, 10, 10'h331);
        tx_check(8'h28, 8'h20, 10, 10'h231);
        tx_check(8'hac, 8'h60, 10, 10'h331);
        tx_check(8'h2c, 8'h60, 10, 10'h231);
    endtask : t_tx

    task automatic t_rx8;
        wr(uart_pkg::ADDR_CTRL, 8'h20);
        wr(uart_pkg::ADDR_MODE, 8'h08);
        peer.send(10'h031, 9);
        ck_rd(uart_pkg::ADDR_INT_STAT, 10'h000);
        wr(uart_pkg::ADDR_MODE, 8'h28);
        peer.send(10'h031, 9);
        ck_rd(uart_pkg::ADDR_INT_STAT, 10'h001);
        ck_rd(uart_pkg::ADDR_CTRL, 10'h020);
        ck_rd(uart_pkg::ADDR_DATA, 10'h031);
        peer.send(10'h131, 9);
        ck_rd(uart_pkg::ADDR_CTRL, 10'h028);
        // Empty the buffer so that the next frame is no overrun.
        ck_rd(uart_pkg::ADDR_DATA, 10'h031);
        wr(uart_pkg::ADDR_INT_CLR, 8'h03);
    endtask : t_rx8

    task automatic t_rx9;
        wr(uart_pkg::ADDR_INT_EN, 8'h01);
        ck_rd(uart_pkg::ADDR_INT_EN, 10'h001);
        wr(uart_pkg::ADDR_MODE, 8'h3c);
        peer.send(10'h055, 9);
        ck_rd(uart_pkg::ADDR_INT_STAT, 10'h000);
        ck_irq(1'b0);
        peer.send(10'h142, 9);
        ck_irq(1'b1);
        // Parity enable is still set; 9-bit frames must ignore it.
        ck_rd(uart_pkg::ADDR_CTRL, 10'h0a0);
        ck_rd(uart_pkg::ADDR_DATA, 10'h042);
        wr(uart_pkg::ADDR_INT_CLR, 8'h01);
        ck_irq(1'b0);
        wr(uart_pkg::ADDR_MODE, 8'h2c);
        peer.send(10'h077, 9);
        ck_rd(uart_pkg::ADDR_CTRL, 10'h020);
        ck_rd(uart_pkg::ADDR_DATA, 10'h077);
        ck_irq(1'b1);
        wr(uart_pkg::ADDR_INT_EN, 8'h00);
        ck_irq(1'b0);
    endtask : t_rx9

    // ****************************************************************
    // Verdict and hang guard.
    // ****************************************************************
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            $display("Error at %0t: run took too long", $time);
            end_of_test();
        end
    end

    initial begin
        arst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset();
        t_tx();
        t_rx8();
        t_rx9();
        end_of_test();
    end
endmodule : tb_top
